// ---- logic/host_bus_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface host_bus_if (
   input wire logic clk,
   input wire logic resetn
);
   import host_port_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] hostData;
   logic [DATA_W-1:0] devData;
   logic [DATA_W-1:0] busData;
   logic hostDataOen;
   logic devDataOen;
   logic registerSelectN;
   logic videoMemSelectN;
   logic lowByteWriteN;
   logic highByteWriteN;
   logic readN;
   logic upperByteEnableN;
   logic hostWidthSelect;
   logic waitN;
   logic stealCycleActive;

   // resolve the two-way data wire; device wins, idle wire floats high
   assign busData = !devDataOen ? devData : (!hostDataOen ? hostData : BUS_IDLE);

   modport device (
      input clk, resetn, addr, busData, registerSelectN, videoMemSelectN,
      input lowByteWriteN, highByteWriteN, readN, upperByteEnableN, hostWidthSelect,
      output devData, devDataOen, waitN, stealCycleActive
   );
   modport host (
      input clk, resetn, busData, waitN, stealCycleActive,
      output addr, hostData, hostDataOen, registerSelectN, videoMemSelectN,
      output lowByteWriteN, highByteWriteN, readN, upperByteEnableN, hostWidthSelect
   );
endinterface
`default_nettype wire

// ---- logic/host_port_device.sv ----
// What this block does
// - register select routes access to registers
// - memory select routes access to video memory
// - low write strobe writes register or memory
// - read strobe drives selected data onto bus
// - high write strobe: memory only, 16-bit
// - width select strap sets 8/16-bit port
// - byte address 8-bit, word address 16-bit
// - address bit 0 and upper enable pick bytes
// - registers decoded from low eight address lines
// - host keeps dual-scan addresses in range
// - reset clears registers and counters
// - port runs on the host system clock
// - 19200 bytes, all directly addressable
// - display fetches take priority over host
// - reduced-pin mode reaches memory via register
// - reduced-pin 16-bit mode: full words only
// - wait low during access, released on clock
// - output shows steal cycle in progress
`timescale 1ns/100ps
`default_nettype none
module host_port_device
   import host_port_pkg::*;
(
   // host bus
   host_bus_if.device bus,
   // configuration strap
   input wire logic reducedPinMode,
   // display fetch side
   input wire logic fetchReq,
   input wire logic [ADDR_W-1:0] fetchAddr,
   output logic [7:0] fetchData,
   output logic fetchValid,
   // control register contents for the display logic
   output logic [8*REG_COUNT-1:0] controlRegs
);
   // ----------------------------------------------------------
   // decode
   // ----------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_LOAD, ST_DONE} dev_state_t;

   dev_state_t state_reg;
   logic [7:0] regFile_reg [REG_COUNT];
   logic [DATA_W-1:0] devData_reg;
   logic wide, selReg, selMem, rdAct, lwrAct, hwrAct, access;
   logic regMapped, portData, needMem, memWrite, grant;
   logic [3:0] regIdx;
   logic [ADDR_W-1:0] ptr, ptr_next, memAddr;
   logic [1:0] lanes;
   logic [DATA_W-1:0] wdata, rdata;
   logic [7:0] regValue;

   // register read value, status composed from live state
   function automatic logic [7:0] regRead(input logic [3:0] idx, input logic [7:0] file,
                                          input logic [7:0] status);
      regRead = (idx == REG_STATUS[3:0]) ? status : file;
   endfunction

   // host clock
   // the whole port runs on the interface clock, which the host supplies
   // width strap
   assign wide = bus.hostWidthSelect;
   assign selReg = !bus.registerSelectN;
   // memory select; direct window closed in reduced mode
   assign selMem = !bus.videoMemSelectN && !reducedPinMode;
   assign rdAct = !bus.readN;
   assign lwrAct = !bus.lowByteWriteN;
   // high strobe only counts for memory in 16-bit mode
   assign hwrAct = !bus.highByteWriteN && wide && selMem;
   assign access = (selReg || selMem) && (rdAct || lwrAct || hwrAct);
   // registers use address 7..0, upper nibble must be zero
   assign regIdx = bus.addr[3:0];
   assign regMapped = bus.addr[7:4] == 4'h0;
   // data port reaches memory through the pointer
   assign portData = selReg && reducedPinMode && bus.addr[7:0] == REG_PORT_DATA;
   assign needMem = selMem || portData;
   assign memWrite = !rdAct;
   assign ptr = {regFile_reg[REG_PTR_HI[3:0]][6:0], regFile_reg[REG_PTR_LO[3:0]]};
   assign ptr_next = ptr + (wide ? 15'h0002 : 15'h0001);
   assign regValue = regMapped ? regRead(regIdx, regFile_reg[regIdx],
      {5'h00, bus.stealCycleActive, reducedPinMode, wide}) : 8'h00;

   // ----------------------------------------------------------
   // memory address, lanes and write data
   // ----------------------------------------------------------
   always_comb begin
      memAddr = portData ? ptr : bus.addr;
      lanes = 2'b01;
      wdata = {bus.busData[7:0], bus.busData[7:0]};
      if (wide) begin
         // 16-bit mode uses lines 14..1 as word address
         memAddr = {memAddr[ADDR_W-1:1], 1'b0};
         wdata = bus.busData;
         if (portData) begin
            // reduced-pin 16-bit port moves whole words
            lanes = 2'b11;
         end else if (hwrAct) begin
            lanes = {1'b1, lwrAct};
         end else begin
            // address bit 0 and upper enable pick the lanes
            lanes = {!bus.upperByteEnableN, !bus.addr[0]};
         end
      end
   end

   // all 19200 bytes behind one arbitrated memory
   vmem_arbiter memory (
      .clk(bus.clk),
      .resetn(bus.resetn),
      .fetchReq(fetchReq),
      .fetchAddr(fetchAddr),
      .fetchData(fetchData),
      .fetchValid(fetchValid),
      .hostReq(state_reg == ST_MEM),
      .hostAddr(memAddr),
      .hostWrite(memWrite),
      .hostLanes(lanes),
      .hostWData(wdata),
      .hostGrant(grant),
      .hostRData(rdata),
      .stealActive(bus.stealCycleActive)
   );
   // steal indicator comes straight from the arbiter flop
   // arbiter serves the fetch first, host waits behind it

   // ----------------------------------------------------------
   // access sequencing
   // ----------------------------------------------------------
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (access) begin
                  state_reg <= needMem ? ST_MEM : ST_DONE;
               end
            end
            // request stays pending until a free slot
            ST_MEM: begin
               if (grant) begin
                  state_reg <= memWrite ? ST_DONE : ST_LOAD;
               end
            end
            ST_LOAD: begin
               state_reg <= ST_DONE;
            end
            // hold here until the host drops its strobe
            ST_DONE: begin
               if (!access) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // wait low while an access is pending, high once done
   assign bus.waitN = !(access && state_reg != ST_DONE);

   // ----------------------------------------------------------
   // control registers and pointer counter
   // ----------------------------------------------------------
   // reset clears every register and the pointer
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regFile_reg[i] <= REG_RESET;
         end
      end else if (state_reg == ST_IDLE && access && !needMem && lwrAct && regMapped
                   && regIdx != REG_STATUS[3:0] && regIdx != REG_PORT_DATA[3:0]) begin
         // register write from the low byte lane
         regFile_reg[regIdx] <= bus.busData[7:0];
      end else if (state_reg == ST_MEM && grant && portData) begin
         // pointer steps one access forward after each data port use
         regFile_reg[REG_PTR_LO[3:0]] <= ptr_next[7:0];
         regFile_reg[REG_PTR_HI[3:0]] <= {1'b0, ptr_next[14:8]};
      end
   end

   // ----------------------------------------------------------
   // read data
   // ----------------------------------------------------------
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         devData_reg <= 16'h0000;
      end else if (state_reg == ST_IDLE && access && !needMem && rdAct) begin
         devData_reg <= {8'h00, regValue};
      end else if (state_reg == ST_LOAD) begin
         devData_reg <= wide ? rdata : {8'h00, rdata[7:0]};
      end
   end

   // drive the bus only while the read strobe is low and wait is released
   assign bus.devData = devData_reg;
   assign bus.devDataOen = !(rdAct && (selReg || selMem) && state_reg == ST_DONE);

   // flat copy of the registers for the display logic
   always_comb begin
      for (int i = 0; i < REG_COUNT; i++) begin
         controlRegs[8*i +: 8] = regFile_reg[i];
      end
   end
endmodule
`default_nettype wire

// ---- logic/host_port_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_port_host
   import host_port_pkg::*;
(
   // host bus
   host_bus_if.host bus,
   // straps
   input wire logic wideBus,
   input wire logic useWriteStrobes,
   // request side
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire space_t reqSpace,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [DATA_W-1:0] reqWData,
   input wire logic [1:0] reqLanes,
   output logic reqReady,
   // answer side
   output logic rspValid,
   output logic [DATA_W-1:0] rspData
);
   // ----------------------------------------------------------
   // cycle sequencer
   // ----------------------------------------------------------
   typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RELEASE} host_state_t;

   host_state_t state_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic write_reg, mem_reg, waited_reg;
   logic [1:0] lanes_reg;
   logic selOn, strobeOn, upperLane, byteMode;

   assign reqReady = state_reg == H_IDLE;
   // byte enables only make sense for 16-bit memory cycles
   assign byteMode = wideBus && mem_reg && !useWriteStrobes;
   assign upperLane = lanes_reg[1] || !wideBus;

   // hold the strobe until wait is seen high; first cycle ignored
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         state_reg <= H_IDLE;
         waited_reg <= 1'b0;
      end else begin
         waited_reg <= state_reg == H_STROBE;
         case (state_reg)
            H_IDLE: begin
               if (reqValid) begin
                  state_reg <= H_SETUP;
               end
            end
            H_SETUP: begin
               state_reg <= H_STROBE;
            end
            H_STROBE: begin
               if (waited_reg && bus.waitN) begin
                  state_reg <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               state_reg <= H_IDLE;
            end
            default: begin
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

   // capture the request when it is taken
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         addr_reg <= 15'h0000;
         data_reg <= 16'h0000;
         write_reg <= 1'b0;
         mem_reg <= 1'b0;
         lanes_reg <= 2'b00;
      end else if (state_reg == H_IDLE && reqValid) begin
         addr_reg <= reqAddr;
         data_reg <= reqWData;
         write_reg <= reqWrite;
         mem_reg <= reqSpace == SPACE_MEM;
         // reduced-pin users pass full lanes for 16-bit words
         lanes_reg <= reqLanes;
      end
   end

   // answer pulse and read data
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         rspValid <= 1'b0;
         rspData <= 16'h0000;
      end else begin
         rspValid <= state_reg == H_STROBE && waited_reg && bus.waitN;
         if (state_reg == H_STROBE && waited_reg && bus.waitN && !write_reg) begin
            rspData <= bus.busData;
         end
      end
   end

   // ----------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------
   assign selOn = state_reg == H_SETUP || state_reg == H_STROBE;
   assign strobeOn = state_reg == H_STROBE;
   // width strap presented to the device
   assign bus.hostWidthSelect = wideBus;
   // caller keeps memory addresses inside the active range
   // bit 0 low selects the lower byte in byte-enable mode
   assign bus.addr = byteMode ? {addr_reg[ADDR_W-1:1], !lanes_reg[0]} : addr_reg;
   assign bus.upperByteEnableN = byteMode ? !lanes_reg[1] : 1'b1;
   assign bus.registerSelectN = !(selOn && !mem_reg);
   assign bus.videoMemSelectN = !(selOn && mem_reg);
   assign bus.readN = !(strobeOn && !write_reg);
   // separate strobes only for 16-bit memory with strobe control
   assign bus.lowByteWriteN = !(strobeOn && write_reg && (lanes_reg[0] || !useWriteStrobes
                                || !wideBus || !mem_reg));
   assign bus.highByteWriteN = !(strobeOn && write_reg && useWriteStrobes && wideBus && mem_reg
                                 && upperLane);
   assign bus.hostData = data_reg;
   assign bus.hostDataOen = !(selOn && write_reg);
endmodule
`default_nettype wire

// ---- logic/host_port_pkg.sv ----
`default_nettype none
package host_port_pkg;
   // ----------------------------------------------------------
   // bus widths and memory size
   // ----------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 16;
   localparam int VMEM_BYTES = 19200;
   localparam int REG_COUNT = 16;
   // ----------------------------------------------------------
   // control register indices (low address byte)
   // ----------------------------------------------------------
   localparam logic [7:0] REG_PTR_LO = 8'h00;
   localparam logic [7:0] REG_PTR_HI = 8'h01;
   localparam logic [7:0] REG_PORT_DATA = 8'h02;
   localparam logic [7:0] REG_STATUS = 8'h03;
   localparam logic [7:0] REG_RESET = 8'h00;
   // status register field positions
   localparam int STATUS_WIDE_BIT = 0;
   localparam int STATUS_REDUCED_BIT = 1;
   localparam int STATUS_STEAL_BIT = 2;
   // value seen on the shared data wire when nobody drives it
   localparam logic [15:0] BUS_IDLE = 16'hffff;
   // access target chosen by the host user
   typedef enum logic {SPACE_REG, SPACE_MEM} space_t;
endpackage
`default_nettype wire

// ---- logic/vmem_arbiter.sv ----
`timescale 1ns/100ps
`default_nettype none
module vmem_arbiter
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // display fetch port
   input wire logic fetchReq,
   input wire logic [ADDR_W-1:0] fetchAddr,
   output logic [7:0] fetchData,
   output logic fetchValid,
   // host port
   input wire logic hostReq,
   input wire logic [ADDR_W-1:0] hostAddr,
   input wire logic hostWrite,
   input wire logic [1:0] hostLanes,
   input wire logic [DATA_W-1:0] hostWData,
   output logic hostGrant,
   output logic [DATA_W-1:0] hostRData,
   output logic stealActive
);
   logic [7:0] mem [VMEM_BYTES];
   logic [ADDR_W-1:0] hiAddr;

   function automatic logic inRange(input logic [ADDR_W-1:0] a);
      inRange = int'(a) < VMEM_BYTES;
   endfunction

   // fetch has priority
   // display fetch always wins; host only gets free slots
   assign hostGrant = hostReq && !fetchReq;
   assign hiAddr = hostAddr + 15'h0001;

   // steal indicator flop
   // read side and steal indicator
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetchData <= 8'h00;
         fetchValid <= 1'b0;
         hostRData <= 16'h0000;
         stealActive <= 1'b0;
      end else begin
         fetchValid <= fetchReq;
         stealActive <= fetchReq;
         if (fetchReq) begin
            fetchData <= inRange(fetchAddr) ? mem[fetchAddr] : 8'h00;
         end
         if (hostGrant && !hostWrite) begin
            hostRData[7:0] <= inRange(hostAddr) ? mem[hostAddr] : 8'h00;
            hostRData[15:8] <= inRange(hiAddr) ? mem[hiAddr] : 8'h00;
         end
      end
   end

   // memory writes; addresses past the end are dropped
   always_ff @(posedge clk) begin
      if (hostGrant && hostWrite) begin
         if (hostLanes[0] && inRange(hostAddr)) begin
            mem[hostAddr] <= hostWData[7:0];
         end
         if (hostLanes[1] && inRange(hiAddr)) begin
            mem[hiAddr] <= hostWData[15:8];
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/host_port_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_port_chk
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // shared bus
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] devData,
   input wire logic devDataOen,
   input wire logic hostDataOen,
   // selects, strobes and wait
   input wire logic registerSelectN,
   input wire logic videoMemSelectN,
   input wire logic lowByteWriteN,
   input wire logic highByteWriteN,
   input wire logic readN,
   input wire logic waitN,
   input wire logic stealCycleActive
);
   logic anySel;
   logic anyStrobe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // any select or any strobe asserted on the wire
   assign anySel = !registerSelectN || !videoMemSelectN;
   assign anyStrobe = !readN || !lowByteWriteN || !highByteWriteN;

   // ----------------------------------------------------------
   // data wire ownership
   // ----------------------------------------------------------
   a_data_only_read: assert property (!devDataOen |-> !readN && anySel)
      else $error("device drives data outside a selected read");
   a_no_bus_fight: assert property (!devDataOen |-> hostDataOen)
      else $error("both ends drive the data wire");
   a_write_drives_data: assert property (anySel && !lowByteWriteN |-> !hostDataOen)
      else $error("write strobe without host data on the wire");
   a_reg_upper_zero: assert property (!devDataOen && !registerSelectN |-> devData[15:8] == 8'h00)
      else $error("register read with nonzero upper byte");

   // ----------------------------------------------------------
   // wait handshake
   // ----------------------------------------------------------
   a_wait_needs_sel: assert property (!anySel |-> waitN)
      else $error("wait low without a select");
   a_wait_needs_strobe: assert property (!anyStrobe |-> waitN)
      else $error("wait low without a strobe");
   a_reg_wait_short: assert property (!registerSelectN && anyStrobe && !waitN |-> ##[1:2] waitN)
      else $error("register access wait too long");
   a_host_holds_wait: assert property (anyStrobe && !waitN |=> anyStrobe && $stable(addr))
      else $error("host dropped cycle while wait low");
   // strobes stay high two cycles so the device can go back to idle
   a_strobe_gap: assert property ($rose(readN) || $rose(lowByteWriteN) |-> !anyStrobe ##1 !anyStrobe)
      else $error("next strobe too soon after release");

   c_reg_read: cover property (!registerSelectN && !readN && waitN);
   c_mem_write: cover property (!videoMemSelectN && !lowByteWriteN && waitN);
   c_steal_wait: cover property (stealCycleActive && !waitN);
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
   import host_port_pkg::*;
   // ----------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic reducedPinMode = 1'b0;
   logic wideBus = 1'b0;
   logic useWriteStrobes = 1'b0;
   logic fetchReq = 1'b0;
   logic [ADDR_W-1:0] fetchAddr = '0;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   space_t reqSpace = SPACE_REG;
   logic [ADDR_W-1:0] reqAddr = '0;
   logic [DATA_W-1:0] reqWData = '0;
   logic [1:0] reqLanes = 2'b01;
   logic reqReady;
   logic rspValid;
   logic fetchValid;
   logic [DATA_W-1:0] rspData;
   logic [7:0] fetchData;
   logic [8*REG_COUNT-1:0] controlRegs;
   logic [DATA_W-1:0] rd;
   int nMismatch = 0;
   int numChecks = 0;

   // 200 MHz system clock
   always #2.5 clk = ~clk;

   host_bus_if host_bus_if_inst (.clk(clk), .resetn(resetn));
   host_port_device host_port_device_inst (.bus(host_bus_if_inst), .reducedPinMode(reducedPinMode),
      .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchData(fetchData), .fetchValid(fetchValid),
      .controlRegs(controlRegs));
   host_port_host host_port_host_inst (.bus(host_bus_if_inst), .wideBus(wideBus),
      .useWriteStrobes(useWriteStrobes), .reqValid(reqValid), .reqWrite(reqWrite), .reqSpace(reqSpace),
      .reqAddr(reqAddr), .reqWData(reqWData), .reqLanes(reqLanes), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData));
   host_port_chk host_port_chk_inst (.clk(clk), .resetn(resetn), .addr(host_bus_if_inst.addr),
      .devData(host_bus_if_inst.devData), .devDataOen(host_bus_if_inst.devDataOen),
      .hostDataOen(host_bus_if_inst.hostDataOen), .registerSelectN(host_bus_if_inst.registerSelectN),
      .videoMemSelectN(host_bus_if_inst.videoMemSelectN), .lowByteWriteN(host_bus_if_inst.lowByteWriteN),
      .highByteWriteN(host_bus_if_inst.highByteWriteN), .readN(host_bus_if_inst.readN),
      .waitN(host_bus_if_inst.waitN), .stealCycleActive(host_bus_if_inst.stealCycleActive));

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic wrapUp();
      if (nMismatch == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one request; held until taken, answer kept in rd
   task automatic access(input logic wr, input space_t sp, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic [1:0] ln);
      int i = 0;
      @(posedge clk);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqSpace <= sp;
      reqAddr <= a;
      reqWData <= d;
      reqLanes <= ln;
      do begin
         @(negedge clk);
         i++;
      end while (reqReady !== 1'b1 && i < 50);
      if (reqReady !== 1'b1) begin
         nMismatch++;
         wrapUp();
      end
      @(posedge clk);
      reqValid <= 1'b0;
      i = 0;
      // no upper bound from the device while fetches run, so keep a generous one
      do begin
         @(negedge clk);
         i++;
      end while (rspValid !== 1'b1 && i < 500);
      if (rspValid !== 1'b1) begin
         nMismatch++;
         wrapUp();
      end
      rd = rspData;
   endtask

   // single display fetch, answer one cycle later
   task automatic fetch(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clk);
      fetchReq <= 1'b1;
      fetchAddr <= a;
      @(posedge clk);
      fetchReq <= 1'b0;
      @(negedge clk);
      `CHK(fetchValid, 1'b1)
      `CHK(host_bus_if_inst.stealCycleActive, 1'b1)
      `CHK(fetchData, e)
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic regScenario();
      access(1'b1, SPACE_REG, 15'h0004, 16'h00a5, 2'b01);
      access(1'b1, SPACE_REG, 15'h010f, 16'h003c, 2'b01);
      access(1'b1, SPACE_REG, 15'h0014, 16'h0077, 2'b01);
      access(1'b0, SPACE_REG, 15'h0004, '0, 2'b01);
      `CHK(rd, 16'h00a5)
      access(1'b0, SPACE_REG, 15'h000f, '0, 2'b01);
      `CHK(rd, 16'h003c)
      access(1'b0, SPACE_REG, 15'h0014, '0, 2'b01);
      `CHK(rd, 16'h0000)
      access(1'b0, SPACE_REG, 15'h0003, '0, 2'b01);
      `CHK(rd, 16'h0000)
      `CHK(controlRegs[39:32], 8'ha5)
      `CHK(controlRegs[127:120], 8'h3c)
   endtask

   // first and last byte, and one past the end
   task automatic mem8Scenario();
      access(1'b1, SPACE_MEM, 15'h0000, 16'h005a, 2'b01);
      access(1'b1, SPACE_MEM, 15'h4aff, 16'h00c3, 2'b01);
      access(1'b1, SPACE_MEM, 15'h4b00, 16'h0011, 2'b01);
      access(1'b0, SPACE_MEM, 15'h4aff, '0, 2'b01);
      `CHK(rd[7:0], 8'hc3)
      access(1'b0, SPACE_MEM, 15'h4b00, '0, 2'b01);
      `CHK(rd[7:0], 8'h00)
      fetch(15'h0000, 8'h5a);
   endtask

   task automatic mem16Scenario();
      @(posedge clk);
      wideBus <= 1'b1;
      access(1'b1, SPACE_MEM, 15'h0064, 16'h1234, 2'b11);
      access(1'b1, SPACE_MEM, 15'h0064, 16'habcd, 2'b01);
      access(1'b1, SPACE_MEM, 15'h0064, 16'h5500, 2'b10);
      access(1'b0, SPACE_MEM, 15'h0064, '0, 2'b11);
      `CHK(rd, 16'h55cd)
      fetch(15'h0064, 8'hcd);
      fetch(15'h0065, 8'h55);
      access(1'b0, SPACE_REG, 15'h0003, '0, 2'b01);
      `CHK(rd, 16'h0001)
      @(posedge clk);
      useWriteStrobes <= 1'b1;
      access(1'b1, SPACE_MEM, 15'h0064, 16'h7700, 2'b10);
      access(1'b1, SPACE_REG, 15'h0006, 16'h9911, 2'b11);
      access(1'b0, SPACE_MEM, 15'h0064, '0, 2'b11);
      `CHK(rd, 16'h77cd)
      `CHK(controlRegs[55:48], 8'h11)
   endtask

   // host read held off by a long display burst
   task automatic stealScenario();
      fork
         begin
            @(posedge clk);
            fetchReq <= 1'b1;
            fetchAddr <= 15'h0064;
            repeat (10) @(posedge clk);
            @(negedge clk);
            `CHK(host_bus_if_inst.waitN, 1'b0)
            `CHK(fetchData, 8'hcd)
            repeat (10) @(posedge clk);
            fetchReq <= 1'b0;
         end
         access(1'b0, SPACE_MEM, 15'h0064, '0, 2'b11);
      join
      `CHK(rd, 16'h77cd)
   endtask

   // memory only through the pointer and data port
   task automatic reducedScenario();
      @(posedge clk);
      reducedPinMode <= 1'b1;
      wideBus <= 1'b0;
      useWriteStrobes <= 1'b0;
      access(1'b1, SPACE_REG, 15'h0000, 16'h002c, 2'b01);
      access(1'b1, SPACE_REG, 15'h0001, 16'h0001, 2'b01);
      access(1'b1, SPACE_REG, 15'h0002, 16'h009e, 2'b01);
      access(1'b1, SPACE_REG, 15'h0002, 16'h004f, 2'b01);
      access(1'b1, SPACE_MEM, 15'h0064, 16'h00ee, 2'b01);
      access(1'b0, SPACE_REG, 15'h0003, '0, 2'b01);
      `CHK(rd, 16'h0002)
      fetch(15'h012c, 8'h9e);
      fetch(15'h012d, 8'h4f);
      fetch(15'h0064, 8'hcd);
      // 16-bit data port moves whole words and steps the pointer by two
      @(posedge clk);
      wideBus <= 1'b1;
      access(1'b1, SPACE_REG, 15'h0000, 16'h0030, 2'b11);
      access(1'b1, SPACE_REG, 15'h0002, 16'hb7a6, 2'b11);
      access(1'b0, SPACE_REG, 15'h0000, '0, 2'b01);
      `CHK(rd, 16'h0032)
      fetch(15'h0130, 8'ha6);
      fetch(15'h0131, 8'hb7);
   endtask

   task automatic resetScenario();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      reducedPinMode <= 1'b0;
      @(negedge clk);
      `CHK(controlRegs, '0)
      access(1'b0, SPACE_REG, 15'h0004, '0, 2'b01);
      `CHK(rd, 16'h0000)
      fetch(15'h4aff, 8'hc3);
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      regScenario();
      mem8Scenario();
      mem16Scenario();
      stealScenario();
      reducedScenario();
      resetScenario();
      wrapUp();
   end
endmodule
`default_nettype wire
